// [hw/sbsc_pkg.sv]
// shared constants, types and helpers of the synchronous burst sram control block
`default_nettype none
package sbsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int ADDR_W   = 16;                    // word address width
    localparam int DATA_W   = 18;                    // word width
    localparam int BYTE_W   = 9;                     // one byte lane
    localparam int NUM_BE   = 2;                     // byte lanes per word
    localparam int WORDS    = 65536;                 // words in the array
    localparam int LO_W     = 2;                     // burst counter width
    localparam int HI_W     = ADDR_W - LO_W;         // fixed upper address bits
    localparam int ENTRY_W  = ADDR_W + NUM_BE + DATA_W;  // write queue entry
    localparam int WQ_DEPTH = 8;                     // write queue words

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [ADDR_W-1:0] RST_ADDR   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DATA   = 18'h00000;
    localparam logic [HI_W-1:0]   RST_BASE   = 14'h0000;
    localparam logic [LO_W-1:0]   RST_CNT    = 2'h0;
    localparam logic [LO_W-1:0]   CNT_STEP   = 2'h1;
    localparam logic              RST_PIN_N  = 1'h1;  // control pins idle high

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic {st_idle, st_burst} sbsc_burst_t;          // burst state
    typedef enum logic [1:0] {op_none, op_read, op_write} sbsc_op_t;  // access

    // linear burst order, wraps modulo four from the loaded start
    function automatic logic [LO_W-1:0] burst_lo(input logic [LO_W-1:0] start,
                                                 input logic [LO_W-1:0] cnt);
        burst_lo = start + cnt;
    endfunction

endpackage
`default_nettype wire

// [hw/sbsc_fifo_if.sv]
// handshake carrier between the burst controller and its write queue
`timescale 1ns/100ps
`default_nettype none
interface sbsc_fifo_if #(
    parameter int W = 8
);
    logic         in_valid;   // producer offers an entry
    logic         in_ready;   // queue has room
    logic [W-1:0] in_data;    // entry offered
    logic         out_valid;  // queue holds an entry
    logic         out_ready;  // consumer takes the head
    logic [W-1:0] out_data;   // head entry

    // the queue side
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    // the controller side
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// [hw/sbsc_fifo.sv]
// parameterised first-in first-out queue with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sbsc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8   // power of two
) (
    input  wire logic   i_sys_clk,
    input  wire logic   i_nrst,
    sbsc_fifo_if.fifo   q
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [0:DEPTH-1];  // queue storage
    logic [PW-1:0] wr_ptr;           // next slot to fill
    logic [PW-1:0] rd_ptr;           // head slot
    logic [PW:0]   count;            // entries held
    logic          push;             // entry accepted
    logic          pop;              // head taken

    ////////////////////////////////////////////////////////////////////////////////
    // honest flags: full and empty come straight from the count
    assign q.in_ready  = (count != DEPTH[PW:0]);
    assign q.out_valid = (count != '0);
    assign q.out_data  = mem[rd_ptr];
    assign push        = q.in_valid & q.in_ready;
    assign pop         = q.out_valid & q.out_ready;

    // storage has no reset, only the pointers and the count matter
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= q.in_data;
        end
    end

    // write pointer
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // occupancy, push and pop together leave it unchanged
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // queue checks
    AST_FIFO_NO_OVER : assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (count == DEPTH[PW:0]) |-> !q.in_ready)
        else $error("queue accepts while full");
endmodule
`default_nettype wire

// [hw/sbsc_top.sv]
// burst controller, byte-writable array and data pin control of the synchronous sram
`timescale 1ns/100ps
`default_nettype none
module sbsc_top #(
    parameter int WQ_DEPTH = sbsc_pkg::WQ_DEPTH  // write queue depth
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_chip_sel_n,
    input  wire logic                        i_processor_start_n,
    input  wire logic                        i_cache_ctrl_start_n,
    input  wire logic                        i_burst_advance_n,
    input  wire logic                        i_low_byte_write_n,
    input  wire logic                        i_high_byte_write_n,
    input  wire logic                        i_output_enable_n,
    input  wire logic [sbsc_pkg::ADDR_W-1:0] i_word_address_bus,
    input  wire logic [sbsc_pkg::DATA_W-1:0] i_data_bus_bits,
    output logic      [sbsc_pkg::DATA_W-1:0] o_data_bus_bits,
    output logic                             o_data_bus_oe,
    output logic                             o_write_ready
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    // input registers, one stage behind the pins
    logic [sbsc_pkg::ADDR_W-1:0] q_addr;       // captured address
    logic [sbsc_pkg::DATA_W-1:0] q_din;        // captured write data
    logic                        q_cs_n;       // captured chip select
    logic                        q_proc_n;     // captured processor start
    logic                        q_cache_n;    // captured cache start
    logic                        q_adv_n;      // captured burst advance
    logic                        q_lw_n;       // captured low strobe
    logic                        q_hw_n;       // captured high strobe

    // burst state
    sbsc_pkg::sbsc_burst_t       state;        // idle or within a burst
    sbsc_pkg::sbsc_burst_t       next_state;
    logic [sbsc_pkg::HI_W-1:0]   base_hi;      // fixed upper bits
    logic [sbsc_pkg::HI_W-1:0]   next_base_hi;
    logic [sbsc_pkg::LO_W-1:0]   start_lo;     // loaded low bits
    logic [sbsc_pkg::LO_W-1:0]   next_start_lo;
    logic [sbsc_pkg::LO_W-1:0]   cnt;          // steps taken from start
    logic [sbsc_pkg::LO_W-1:0]   next_cnt;

    // decode of the captured cycle
    logic                        new_p;        // processor start seen
    logic                        new_c;        // cache start seen alone
    logic                        load;         // a new base address cycle
    logic                        any_wr;       // a strobe is low
    logic                        step;         // continue cycle that advances
    sbsc_pkg::sbsc_op_t          op;           // access performed this cycle
    logic [sbsc_pkg::ADDR_W-1:0] acc_addr;     // address of that access
    logic [sbsc_pkg::NUM_BE-1:0] be;           // byte lanes written

    // array and read path
    logic [sbsc_pkg::DATA_W-1:0] mem [0:sbsc_pkg::WORDS-1];
    logic [sbsc_pkg::DATA_W-1:0] rd_data;      // word on the data pins
    logic                        rd_phase;     // previous cycle was a read
    logic [sbsc_pkg::ADDR_W-1:0] wq_addr;      // head entry address
    logic [sbsc_pkg::NUM_BE-1:0] wq_be;        // head entry lanes
    logic [sbsc_pkg::DATA_W-1:0] wq_data;      // head entry data
    logic                        wq_fire;      // head retires into the array

    // write queue carrier
    sbsc_fifo_if #(.W(sbsc_pkg::ENTRY_W)) wq_if ();

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // merge a pending queued write over a word read from the array, so that
    // a read right behind a write never sees stale bytes
    function automatic logic [sbsc_pkg::DATA_W-1:0] merge_fwd(
        input logic [sbsc_pkg::DATA_W-1:0] word,
        input logic                        hit,
        input logic [sbsc_pkg::NUM_BE-1:0] lanes,
        input logic [sbsc_pkg::DATA_W-1:0] newer
    );
        logic [sbsc_pkg::DATA_W-1:0] res;
        res = word;
        for (int i = 0; i < sbsc_pkg::NUM_BE; i++) begin
            if (hit && lanes[i]) begin
                res[i*sbsc_pkg::BYTE_W +: sbsc_pkg::BYTE_W] =
                    newer[i*sbsc_pkg::BYTE_W +: sbsc_pkg::BYTE_W];
            end
        end
        merge_fwd = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // input registers

    // every pin except output enable passes one rising-edge register;
    // the far side runs on this same clock so no synchroniser is used
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            q_addr    <= sbsc_pkg::RST_ADDR;
            q_din     <= sbsc_pkg::RST_DATA;
            q_cs_n    <= sbsc_pkg::RST_PIN_N;
            q_proc_n  <= sbsc_pkg::RST_PIN_N;
            q_cache_n <= sbsc_pkg::RST_PIN_N;
            q_adv_n   <= sbsc_pkg::RST_PIN_N;
            q_lw_n    <= sbsc_pkg::RST_PIN_N;
            q_hw_n    <= sbsc_pkg::RST_PIN_N;
        end else begin
            q_addr    <= i_word_address_bus;
            q_din     <= i_data_bus_bits;
            q_cs_n    <= i_chip_sel_n;
            q_proc_n  <= i_processor_start_n;
            q_cache_n <= i_cache_ctrl_start_n;
            q_adv_n   <= i_burst_advance_n;
            q_lw_n    <= i_low_byte_write_n;
            q_hw_n    <= i_high_byte_write_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cycle decode

    // processor start wins over cache start and over the strobes
    assign new_p  = !q_proc_n;
    assign new_c  = q_proc_n && !q_cache_n;
    assign load   = new_p || new_c;
    assign any_wr = !q_lw_n || !q_hw_n;
    assign be     = {!q_hw_n, !q_lw_n};
    assign step   = !load && (state == sbsc_pkg::st_burst) && !q_adv_n;

    // next burst state and this cycle's access
    always_comb begin
        next_state    = state;
        next_base_hi  = base_hi;
        next_start_lo = start_lo;
        next_cnt      = cnt;
        op            = sbsc_pkg::op_none;
        acc_addr      = {base_hi, sbsc_pkg::burst_lo(start_lo, cnt)};
        if (load) begin
            if (q_cs_n) begin
                // deselected: no access, burst ends
                next_state = sbsc_pkg::st_idle;
            end else begin
                // new base: upper bits fixed, low bits seed the counter
                next_state    = sbsc_pkg::st_burst;
                next_base_hi  = q_addr[sbsc_pkg::ADDR_W-1:sbsc_pkg::LO_W];
                next_start_lo = q_addr[sbsc_pkg::LO_W-1:0];
                next_cnt      = sbsc_pkg::RST_CNT;
                acc_addr      = q_addr;
                if (new_c && any_wr) begin
                    op = sbsc_pkg::op_write;
                end else begin
                    op = sbsc_pkg::op_read;
                end
            end
        end else begin
            unique case (state)
                sbsc_pkg::st_idle: begin
                    // no burst to continue, chip select is not looked at
                    op = sbsc_pkg::op_none;
                end
                sbsc_pkg::st_burst: begin
                    // chip select ignored; advance steps before the access
                    if (!q_adv_n) begin
                        next_cnt = cnt + sbsc_pkg::CNT_STEP;
                    end
                    // modulo-four sum wraps to the start after the fourth
                    acc_addr = {base_hi, sbsc_pkg::burst_lo(start_lo, next_cnt)};
                    if (any_wr) begin
                        op = sbsc_pkg::op_write;
                    end else begin
                        op = sbsc_pkg::op_read;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst state registers

    // burst mode flag
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state <= sbsc_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // base address and counter; a held advance leaves cnt alone
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            base_hi  <= sbsc_pkg::RST_BASE;
            start_lo <= sbsc_pkg::RST_CNT;
            cnt      <= sbsc_pkg::RST_CNT;
        end else begin
            base_hi  <= next_base_hi;
            start_lo <= next_start_lo;
            cnt      <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed write queue

    // a write is captured whole on the edge and finished without any pulse
    // from outside; the queue lets it retire when the array port is free
    assign wq_if.in_valid  = (op == sbsc_pkg::op_write);
    assign wq_if.in_data   = {acc_addr, be, q_din};
    // reads own the single array port, so the drain stalls under them
    assign wq_if.out_ready = (op != sbsc_pkg::op_read);
    assign {wq_addr, wq_be, wq_data} = wq_if.out_data;
    assign wq_fire         = wq_if.out_valid && wq_if.out_ready;
    assign o_write_ready   = wq_if.in_ready;

    sbsc_fifo #(
        .W     (sbsc_pkg::ENTRY_W),
        .DEPTH (WQ_DEPTH)
    ) u_wq (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .q         (wq_if.fifo)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // storage array

    // each lane is written only under its own strobe
    always_ff @(posedge i_sys_clk) begin
        if (wq_fire && wq_be[0]) begin
            mem[wq_addr][sbsc_pkg::BYTE_W-1:0] <= wq_data[sbsc_pkg::BYTE_W-1:0];
        end
        if (wq_fire && wq_be[1]) begin
            mem[wq_addr][sbsc_pkg::DATA_W-1:sbsc_pkg::BYTE_W] <=
                wq_data[sbsc_pkg::DATA_W-1:sbsc_pkg::BYTE_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path and data pins

    // read word, kept while no new read arrives
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rd_data <= sbsc_pkg::RST_DATA;
        end else if (op == sbsc_pkg::op_read) begin
            rd_data <= merge_fwd(mem[acc_addr], wq_if.out_valid && (wq_addr == acc_addr),
                                 wq_be, wq_data);
        end
    end

    // drive window: only a read cycle opens it, writes and deselects close it
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rd_phase <= 1'b0;
        end else begin
            rd_phase <= (op == sbsc_pkg::op_read);
        end
    end

    // output enable is not registered: it gates the pins at once
    assign o_data_bus_bits = rd_data;
    assign o_data_bus_oe   = rd_phase && !i_output_enable_n;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // a selected base load followed by advancing continue cycles
    sequence s_load_sel;
        load && !q_cs_n;
    endsequence
    sequence s_adv;
        step;
    endsequence

    AST_CAPTURE : assert property (
        i_nrst |=> (q_addr == $past(i_word_address_bus)) && (q_din == $past(i_data_bus_bits)))
        else $error("pins not captured on the edge");

    AST_ARRAY_SPAN : assert property (
        wq_if.in_valid |-> ($bits(acc_addr) == sbsc_pkg::ADDR_W) && (wq_if.in_data[sbsc_pkg::DATA_W-1:0] == q_din))
        else $error("queued word does not carry the captured data");

    AST_WR_DRAIN : assert property (
        (op == sbsc_pkg::op_write) ##1 (op != sbsc_pkg::op_read) |-> wq_fire)
        else $error("queued write not retired on a free cycle");

    AST_LANES : assert property (
        wq_if.in_valid |-> (wq_if.in_data[sbsc_pkg::DATA_W +: sbsc_pkg::NUM_BE] == {!q_hw_n, !q_lw_n}))
        else $error("byte lanes do not follow the strobes");

    AST_WR_WHEN_STROBE : assert property (
        (!load && state == sbsc_pkg::st_burst && any_wr) |-> (op == sbsc_pkg::op_write))
        else $error("strobe low but no write in burst");

    AST_PROC_READ : assert property (
        (new_p && !q_cs_n) |-> (op == sbsc_pkg::op_read) && (acc_addr == q_addr))
        else $error("processor start did not read the new address");

    AST_CACHE_WRITE : assert property (
        (new_c && !q_cs_n && any_wr) |-> (op == sbsc_pkg::op_write) && (acc_addr == q_addr))
        else $error("cache start write not at new address");

    AST_DESELECT : assert property (
        (load && q_cs_n) |-> (op == sbsc_pkg::op_none) ##1 !o_data_bus_oe)
        else $error("deselected cycle performed an access");

    AST_IGNORE_CS : assert property (
        (!load && state == sbsc_pkg::st_burst && q_cs_n) |-> (op != sbsc_pkg::op_none))
        else $error("chip select honoured inside a burst");

    AST_WAIT : assert property (
        (!load && state == sbsc_pkg::st_burst && q_adv_n) |=> $stable(cnt))
        else $error("counter moved during a wait state");

    AST_WRAP : assert property (
        s_load_sel ##1 s_adv[*4] |-> (acc_addr == $past(acc_addr, 4)))
        else $error("burst did not wrap to its start after four steps");

    AST_STEP : assert property (
        s_load_sel ##1 s_adv |-> (acc_addr[1:0] == $past(acc_addr[1:0]) + 2'h1)
                                 && (acc_addr[15:2] == $past(acc_addr[15:2])))
        else $error("burst step is not linear or moved upper bits");

    AST_HIZ_WRITE : assert property (
        (op != sbsc_pkg::op_read) |=> !o_data_bus_oe)
        else $error("pins driven after a non-read cycle");

endmodule
`default_nettype wire

// [bench/sbsc_host.sv]
// host model: processor or cache controller driving burst cycles on the sram pins
`timescale 1ns/100ps
`default_nettype none
module sbsc_host (
    output var logic        o_cs_n,   // chip select
    output var logic        o_ps_n,   // processor start
    output var logic        o_cc_n,   // cache controller start
    output var logic        o_adv_n,  // burst advance
    output var logic        o_lw_n,   // low byte strobe
    output var logic        o_hw_n,   // high byte strobe
    output var logic        o_oe_n,   // output enable
    output var logic [15:0] o_addr,   // word address
    output var logic [17:0] o_dq,     // write data
    output var logic        o_dq_en   // host drives the data pins
);
    // idle bus at time zero: every control high, data released
    initial begin
        {o_cs_n, o_ps_n, o_cc_n, o_adv_n, o_lw_n, o_hw_n, o_oe_n} = 7'h7f;
        o_addr  = 16'h0000;
        o_dq    = 18'h00000;
        o_dq_en = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one pin cycle, called just after a falling edge; c = cs,ps,cc,adv,lw,hw,oe
    task automatic put(input logic [6:0] c, input logic [15:0] a, input logic [17:0] d);
        logic wr;
        // processor start outranks strobes, so only without it is a strobe a write
        wr = c[5] & ~(c[2] & c[1]);
        {o_cs_n, o_ps_n, o_cc_n, o_adv_n, o_lw_n, o_hw_n} = c[6:1];
        // output enable forced high on writes so pins never fight
        o_oe_n  = c[0] | wr;
        o_addr  = a;
        o_dq    = d;
        o_dq_en = wr;
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the synchronous burst sram control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [6:0]  c;  // controls cs,ps,cc,adv,lw,hw,oe
        logic [15:0] a;  // address
        logic [17:0] d;  // write data
        logic        rd; // a read result is due
        logic [17:0] q;  // read word due
    } sbsc_row_t;
    localparam int N = 20;
    localparam int LIMIT = 400;  // whole run needs about 32 cycles
    // 5 burst write wraps at the start, 5 read it back, then aborts and deselects
    sbsc_row_t rows [N] = '{
        '{7'h28, 16'h1232, 18'h2aaaa, 1'h0, 18'h00000},
        '{7'h70, 16'hffff, 18'h15555, 1'h0, 18'h00000},
        '{7'h70, 16'hffff, 18'h0f0f0, 1'h0, 18'h00000},
        '{7'h70, 16'hffff, 18'h3c3c3, 1'h0, 18'h00000},
        '{7'h72, 16'hffff, 18'h001ff, 1'h0, 18'h00000},
        '{7'h2e, 16'h1232, 18'h00000, 1'h1, 18'h2abff},
        '{7'h7e, 16'h0000, 18'h00000, 1'h1, 18'h2abff},
        '{7'h76, 16'h0000, 18'h00000, 1'h1, 18'h15555},
        '{7'h76, 16'h0000, 18'h00000, 1'h1, 18'h0f0f0},
        '{7'h76, 16'h0000, 18'h00000, 1'h1, 18'h3c3c3},
        '{7'h08, 16'h1233, 18'h3ffff, 1'h1, 18'h15555},
        '{7'h76, 16'h0000, 18'h00000, 1'h1, 18'h0f0f0},
        '{7'h1e, 16'h1231, 18'h00000, 1'h1, 18'h3c3c3},
        '{7'h7c, 16'h0000, 18'h3fe00, 1'h0, 18'h00000},
        '{7'h2e, 16'h1231, 18'h00000, 1'h1, 18'h3ffc3},
        '{7'h6e, 16'h1232, 18'h00000, 1'h0, 18'h00000},
        '{7'h76, 16'h0000, 18'h00000, 1'h0, 18'h00000},
        '{7'h2e, 16'h1233, 18'h00000, 1'h1, 18'h15555},
        '{7'h76, 16'h0000, 18'h00000, 1'h1, 18'h0f0f0},
        '{7'h5e, 16'h1232, 18'h00000, 1'h0, 18'h00000}};
    logic        i_sys_clk = 1'h0;  // 125 mhz clock
    logic        i_nrst    = 1'h0;  // synchronous reset, active low
    logic        cs_n, ps_n, cc_n, adv_n, lw_n, hw_n, oe_n;
    logic [15:0] addr;
    logic [17:0] h_dq, dq, o_dq, dq_last = 18'h00000;
    logic        h_en, o_oe, o_wr_rdy, pend = 1'h0;
    logic [17:0] pq = 18'h00000;       // read word owed by the previous cycle
    int          failures = 0, n_checks = 0, cycles = 0;

    always #4 i_sys_clk = ~i_sys_clk;
    // pin level: device, else host, else a changing value so a stale word never passes
    assign dq = o_oe ? o_dq : (h_en ? h_dq : ~dq_last);
    always @(posedge i_sys_clk) dq_last <= dq;

    sbsc_host host (.o_cs_n(cs_n), .o_ps_n(ps_n), .o_cc_n(cc_n), .o_adv_n(adv_n),
        .o_lw_n(lw_n), .o_hw_n(hw_n), .o_oe_n(oe_n), .o_addr(addr), .o_dq(h_dq),
        .o_dq_en(h_en));
    sbsc_top dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_chip_sel_n(cs_n),
        .i_processor_start_n(ps_n), .i_cache_ctrl_start_n(cc_n), .i_burst_advance_n(adv_n),
        .i_low_byte_write_n(lw_n), .i_high_byte_write_n(hw_n), .i_output_enable_n(oe_n),
        .i_word_address_bus(addr), .i_data_bus_bits(dq), .o_data_bus_bits(o_dq),
        .o_data_bus_oe(o_oe), .o_write_ready(o_wr_rdy));

    ////////////////////////////////////////////////////////////////////////////////
    // compare tasks and closing report
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [17:0] e, input logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, counted as a mismatch
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            wrap_up();
        end
    end

    // one pin cycle: drive, let it be sampled, then judge what the last cycle owed
    task automatic step(input sbsc_row_t r);
        host.put(r.c, r.a, r.d);
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk_bit("data_oe", pend & ~oe_n, o_oe);
        chk_bit("write_ready", 1'h1, o_wr_rdy);
        if (pend) chk_word("read_data", pq, o_dq);
        pend = r.rd;
        pq   = r.q;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(negedge i_sys_clk);
        i_nrst = 1'h1;
        chk_bit("data_oe", 1'h0, o_oe);
        chk_word("read_data", 18'h00000, o_dq);
        foreach (rows[i]) step(rows[i]);
        // a read caught by a second reset must not reach the pins
        host.put(7'h2e, 16'h1230, 18'h00000);
        @(negedge i_sys_clk);
        i_nrst = 1'h0;
        @(negedge i_sys_clk);
        chk_bit("data_oe", 1'h0, o_oe);
        chk_word("read_data", 18'h00000, o_dq);
        i_nrst = 1'h1;
        // continue cycles right after reset find no burst to continue
        step('{7'h76, 16'h0000, 18'h00000, 1'h0, 18'h00000});
        step('{7'h7f, 16'h0000, 18'h00000, 1'h0, 18'h00000});
        wrap_up();
    end
endmodule
`default_nettype wire
